// file: bench/pmbcs_power_ctrl_monitor.sv
// Watches the power mode and bus clock ports of the controller.
module pmbcs_power_mon #(
    parameter NUM_PERIPH = 8,
    parameter PRIO_W     = 3
) (
    input logic                  mclk,
    input logic                  sys_rst,
    input logic                  wait_exec,
    input logic                  irq_pending,
    input logic                  irq_sleep_capable,
    input logic [PRIO_W-1:0]     irq_priority,
    input logic [PRIO_W-1:0]     cpu_priority,
    input logic                  any_reset,
    input logic                  watchdog_timeout,
    input logic                  src_needs_start,
    input logic [NUM_PERIPH-1:0] stop_in_idle_bit,
    input logic                  periph_rd_req,
    input logic [31:0]           oscillator_control_reg,
    input logic                  cpu_halt,
    input logic                  core_system_clock_en,
    input logic                  peripheral_bus_clock_en,
    input logic [NUM_PERIPH-1:0] periph_clk_en,
    input logic                  periph_rd_done,
    input logic [1:0]            power_mode,
    input logic                  cpu_wake_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Wake events are excluded so a simultaneous reset does not mask entry.
    a_idle_entry: assert property (power_mode == 2'h0 && wait_exec && !oscillator_control_reg[4] && !any_reset && !watchdog_timeout |=> power_mode == 2'h1) else $error("idle not entered");
    a_sleep_entry: assert property (power_mode == 2'h0 && wait_exec && oscillator_control_reg[4] && !any_reset && !watchdog_timeout |=> power_mode == 2'h2) else $error("sleep not entered");
    a_sleep_clocks: assert property (power_mode == 2'h2 [*3] |-> !peripheral_bus_clock_en && !core_system_clock_en) else $error("clocks run in sleep");
    a_idle_clock: assert property (power_mode == 2'h1 |-> cpu_halt && core_system_clock_en) else $error("idle clocking wrong");
    a_idle_mask: assert property (power_mode == 2'h1 && $past(power_mode) == 2'h1 |-> (periph_clk_en & $past(stop_in_idle_bit)) == '0) else $error("stopped peripheral clocked");
    a_idle_wake: assert property (power_mode == 2'h1 && irq_pending && irq_priority > cpu_priority |=> power_mode == 2'h0) else $error("idle wake missed");
    a_idle_hold: assert property (power_mode == 2'h1 && irq_pending && irq_priority <= cpu_priority && !any_reset && !watchdog_timeout |=> power_mode == 2'h1) else $error("idle left on low priority");
    a_event_wake: assert property (power_mode inside {2'h1, 2'h2} && (any_reset || watchdog_timeout) && !src_needs_start |=> power_mode == 2'h0) else $error("reset or watchdog wake missed");
    a_sleep_low: assert property (power_mode == 2'h2 && irq_pending && irq_sleep_capable && irq_priority <= cpu_priority && !any_reset && !watchdog_timeout |=> power_mode == 2'h1) else $error("low wake not to idle");
    a_start_delay: assert property (power_mode == 2'h2 && (watchdog_timeout || any_reset) && src_needs_start |=> power_mode == 2'h3 ##[3:5] power_mode == 2'h0) else $error("start-up delay wrong");
    a_read_wait: assert property (periph_rd_req && oscillator_control_reg[20:19] == 2'h3 |-> ##[1:8] periph_rd_done) else $error("slow read latency");
    a_wake_flag: assert property (power_mode == 2'h1 && irq_pending && irq_priority > cpu_priority |=> cpu_wake_irq) else $error("wake flag missing");
    a_run_quiet: assert property (power_mode == 2'h0 |=> !cpu_wake_irq) else $error("wake flag in run");
    a_low_quiet: assert property (power_mode == 2'h2 && irq_priority <= cpu_priority |=> !cpu_wake_irq) else $error("wake flag on low wake");
endmodule // pmbcs_power_mon

bind pmbcs_power_ctrl pmbcs_power_mon #(.NUM_PERIPH(NUM_PERIPH), .PRIO_W(PRIO_W)) u_mon (
    .mclk(mclk), .sys_rst(sys_rst), .wait_exec(wait_exec), .irq_pending(irq_pending),
    .irq_sleep_capable(irq_sleep_capable), .irq_priority(irq_priority), .cpu_priority(cpu_priority),
    .any_reset(any_reset), .watchdog_timeout(watchdog_timeout), .src_needs_start(src_needs_start),
    .stop_in_idle_bit(stop_in_idle_bit), .periph_rd_req(periph_rd_req),
    .oscillator_control_reg(oscillator_control_reg), .cpu_halt(cpu_halt),
    .core_system_clock_en(core_system_clock_en), .peripheral_bus_clock_en(peripheral_bus_clock_en),
    .periph_clk_en(periph_clk_en), .periph_rd_done(periph_rd_done), .power_mode(power_mode),
    .cpu_wake_irq(cpu_wake_irq)
);

// file: bench/pmbcs_power_ctrl_tb.sv
module pmbcs_power_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk=0, sys_rst=1, wr=0, wx=0, ip=0, isc=0, ars=0, wdt=0, sns=0, rdq=0;
    logic [31:0] wd=32'h0;
    logic [2:0]  ipr=3'h0, cpr=3'h2;
    logic [7:0]  sib=8'h0F;
    wire  [31:0] ocr;
    wire  [7:0]  pce;
    wire  [1:0]  pm;
    wire         halt, sce, pbce, rdd, wk;
    int          fail_count=0, num_checks=0, i, n;
    // Start-up delay shortened so the run stays short.
    pmbcs_power_ctrl #(.START_DLY_CYC(16'h0004)) dut (.mclk(mclk), .sys_rst(sys_rst), .osc_ctrl_wr(wr),
        .osc_ctrl_wdata(wd), .wait_exec(wx), .irq_pending(ip), .irq_sleep_capable(isc), .irq_priority(ipr),
        .cpu_priority(cpr), .any_reset(ars), .watchdog_timeout(wdt), .src_needs_start(sns),
        .stop_in_idle_bit(sib), .periph_rd_req(rdq), .oscillator_control_reg(ocr), .cpu_halt(halt),
        .core_system_clock_en(sce), .peripheral_bus_clock_en(pbce), .periph_clk_en(pce),
        .periph_rd_done(rdd), .power_mode(pm), .cpu_wake_irq(wk));
    // Free-running system clock.
    initial forever #5 mclk = ~mclk;
    // Wide enough for the packed reset snapshot.
    task chk(input logic [63:0] s, e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task test_done;
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Bounded wait for a mode; a hang ends the run at once.
    task wt(input logic [1:0] e);
        for (i = 0; i < 40 && pm !== e; i++) @(posedge mclk);
        chk(pm, e);
        if (pm !== e) test_done;
    endtask
    // One-cycle pulse; mask bits are wait, watchdog, reset event and read.
    task pls(input logic [3:0] m);
        @(posedge mclk) {wx, wdt, ars, rdq} <= m;
        @(posedge mclk) {wx, wdt, ars, rdq} <= 4'h0;
    endtask
    task wrc(input logic [31:0] v);
        @(posedge mclk) begin wr <= 1; wd <= v; end
        @(posedge mclk) wr <= 0;
    endtask
    task t_idle;
        wrc(32'h0); pls(4'h8); wt(2'h1); chk(sce, 1);
        @(posedge mclk) begin ip <= 1; ipr <= 3'h2; end
        repeat (5) @(posedge mclk);
        chk(pm, 2'h1);
        chk(pce, 8'hF0);
        @(posedge mclk) ipr <= 3'h5;
        wt(2'h0);
        chk(wk, 1);
        @(posedge mclk) ip <= 0;
    endtask
    task t_sleep;
        wrc(32'h10); pls(4'h8); wt(2'h2);
        repeat (3) @(posedge mclk);
        chk({pbce, sce}, 0);
        @(posedge mclk) begin ip <= 1; isc <= 1; ipr <= 3'h1; end
        wt(2'h1);
        @(posedge mclk) ip <= 0;
        pls(4'h4); wt(2'h0);
        pls(4'h8); wt(2'h2); sns <= 1;
        pls(4'h2); wt(2'h3); wt(2'h0);
        sns <= 0;
    endtask
    // The interval between bus enables must equal the divide ratio.
    task t_div;
        for (int d = 0; d < 4; d++) begin
            wrc({11'h0, d[1:0], 19'h0});
            repeat (9) @(posedge mclk);
            for (i = 0; i < 20 && pbce !== 1; i++) @(posedge mclk);
            @(posedge mclk);
            for (n = 1; n < 20 && pbce !== 1; n++) @(posedge mclk);
            chk(n, 1 << d);
            chk({pce, sce}, 9'h1FF);
            pls(4'h1);
            for (n = 0; n < 20 && rdd !== 1; n++) @(posedge mclk);
            chk(n < (1 << d) + 1, 1);
        end
    endtask
    // Reset, scenarios and a global limit against hangs.
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 0;
        @(posedge mclk);
        chk({ocr, pm, halt, sce, pbce, pce, rdd, wk}, 47'h800);
        t_div; t_idle; t_sleep;
        test_done;
    end
    initial begin
        #200000;
        fail_count++;
        test_done;
    end
endmodule // pmbcs_power_ctrl_tb

// file: hw/pmbcs_defines.vh
`ifndef PMBCS_DEFINES_VH
`define PMBCS_DEFINES_VH

// Bit positions inside the oscillator control register image.
`define PMBCS_SLEEP_SEL_BIT     4
`define PMBCS_DIV_MSB           20
`define PMBCS_DIV_LSB           19

// Divisor field codes, ascending ratio.
`define PMBCS_DIV_1             2'h0
`define PMBCS_DIV_2             2'h1
`define PMBCS_DIV_4             2'h2
`define PMBCS_DIV_8             2'h3

// Power mode codes.
`define PMBCS_MODE_RUN          2'h0
`define PMBCS_MODE_IDLE         2'h1
`define PMBCS_MODE_SLEEP        2'h2
`define PMBCS_MODE_START        2'h3

// Reset values.
`define PMBCS_OSC_CTRL_RST      32'h00000000

// Default oscillator start-up plus PLL lock delay in system clocks.
`define PMBCS_START_DLY_CYC     16'h0400

`endif

// file: hw/pmbcs_pb_divider.v
`include "pmbcs_defines.vh"

// Prescaler that makes the peripheral bus clock enable from the system clock.
module pmbcs_pb_divider (
    input  wire       mclk,
    input  wire       sys_rst,
    input  wire       run,
    input  wire [1:0] div_sel,
    output reg        pb_tick
);

    reg [2:0] cnt_q;
    reg [2:0] cnt_d;
    reg [2:0] last;

    // Tick condition, shared by the counter restart and the strobe so they never disagree.
    function at_last;
        input [2:0] cnt;
        input [2:0] lim;
        begin
            at_last = (cnt >= lim);
        end
    endfunction

    // Terminal count per ratio; the counter restarts on every tick so a ratio
    // change takes effect at the next peripheral edge without a glitch.
    always @* begin
        case (div_sel)
            `PMBCS_DIV_1: last = 3'h0;
            `PMBCS_DIV_2: last = 3'h1;
            `PMBCS_DIV_4: last = 3'h3;
            default:      last = 3'h7;
        endcase
        cnt_d = at_last(cnt_q, last) ? 3'h0 : cnt_q + 3'h1;
    end

    // The tick stands still while the bus clock is stopped.
    always @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q   <= 3'h0;
            pb_tick <= 1'b0;
        end else if (run) begin
            cnt_q   <= cnt_d;
            pb_tick <= at_last(cnt_q, last);
        end else begin
            cnt_q   <= 3'h0;
            pb_tick <= 1'b0;
        end
    end

endmodule // pmbcs_pb_divider

// file: hw/pmbcs_power_ctrl.v
`include "pmbcs_defines.vh"

// Summary of operation
// (R1) Wait with sleep-on-wait select clear (bit 4) enters Idle.
// (R2) Idle halts the CPU but keeps the system clock running.
// (R3) In Idle, peripherals with their stop-in-idle bit set halt.
// (R4) Idle wakes on enabled interrupt with priority above CPU priority only.
// (R5) Any reset or watchdog time-out also exits Idle.
// (R6) Sleep wakes on qualified interrupt, any reset, or watchdog time-out.
// (R7) Low-priority Sleep wake keeps CPU halted, restarts bus clock, enters Idle.
// (R8) Divisor field bits 20:19 selects ratios 1:1, 1:2, 1:4, 1:8.
// (R9) Peripheral bus users follow divisor; system-clock blocks are unaffected.
// (R10) Peripheral read completes on next bus clock edge, up to seven waits.
// (R11) Enabling a stopped crystal/PLL source adds start-up delay; Idle exit none.
// (R12) Software picks largest adequate divisor and recomputes peripheral timing.
// (R13) Divisor codes ascend: 00 1:1, 01 1:2, 10 1:4, 11 1:8.
// (R14) Wait with select set enters Sleep, stopping CPU and bus clock.
module pmbcs_power_ctrl #(
    parameter        NUM_PERIPH    = 8,
    parameter        PRIO_W        = 3,
    parameter [15:0] START_DLY_CYC = `PMBCS_START_DLY_CYC
) (
    input  wire                  mclk,
    input  wire                  sys_rst,
    input  wire                  osc_ctrl_wr,
    input  wire [31:0]           osc_ctrl_wdata,
    input  wire                  wait_exec,
    input  wire                  irq_pending,
    input  wire                  irq_sleep_capable,
    input  wire [PRIO_W-1:0]     irq_priority,
    input  wire [PRIO_W-1:0]     cpu_priority,
    input  wire                  any_reset,
    input  wire                  watchdog_timeout,
    input  wire                  src_needs_start,
    input  wire [NUM_PERIPH-1:0] stop_in_idle_bit,
    input  wire                  periph_rd_req,
    output reg  [31:0]           oscillator_control_reg,
    output reg                   cpu_halt,
    output reg                   core_system_clock_en,
    output reg                   peripheral_bus_clock_en,
    output reg  [NUM_PERIPH-1:0] periph_clk_en,
    output reg                   periph_rd_done,
    output reg  [1:0]            power_mode,
    output reg                   cpu_wake_irq
);

    // Sequencer states, binary coded; they double as the power_mode code.
    localparam [1:0] ST_RUN   = `PMBCS_MODE_RUN;
    localparam [1:0] ST_IDLE  = `PMBCS_MODE_IDLE;
    localparam [1:0] ST_SLEEP = `PMBCS_MODE_SLEEP;
    localparam [1:0] ST_START = `PMBCS_MODE_START;

    // Constants sized to the counter and the enable vector.
    localparam [15:0]           DLY_ZERO  = 16'h0000;
    localparam [15:0]           DLY_ONE   = 16'h0001;
    localparam [NUM_PERIPH-1:0] PCLK_NONE = {NUM_PERIPH{1'b0}};

    reg  [1:0]  mode_q;
    reg  [1:0]  mode_d;
    reg  [15:0] dly_q;
    reg  [15:0] dly_d;
    reg         rd_wait_q;
    wire        pb_tick;
    wire        bus_run;
    wire        sleep_on_wait_select;
    wire [1:0]  periph_bus_divisor;
    wire        prio_ok;
    wire        irq_wake;
    wire        wdt_or_rst;
    wire        start_entry;

    // True in the modes in which the system clock source is kept running.
    function clk_src_on;
        input [1:0] mode;
        begin
            clk_src_on = (mode == ST_RUN) || (mode == ST_IDLE);
        end
    endfunction

    // True when a qualified interrupt may end the given low-power mode. In Sleep
    // only a source that keeps running there can wake the core.
    function irq_can_wake;
        input [1:0] mode;
        input       qualified;
        input       sleep_capable;
        begin
            case (mode)
                ST_IDLE:  irq_can_wake = qualified;
                ST_SLEEP: irq_can_wake = qualified && sleep_capable;
                default:  irq_can_wake = 1'b0;
            endcase
        end
    endfunction

    // True when a request is strictly above the CPU; a tie must not wake.
    function prio_above;
        input [PRIO_W-1:0] req_prio;
        input [PRIO_W-1:0] cur_prio;
        begin
            prio_above = (req_prio > cur_prio);
        end
    endfunction

    // Field decode of the control image.
    assign sleep_on_wait_select = oscillator_control_reg[`PMBCS_SLEEP_SEL_BIT]; // (R1) (R14)
    assign periph_bus_divisor   = oscillator_control_reg[`PMBCS_DIV_MSB:`PMBCS_DIV_LSB]; // (R8)

    // Strictly greater priority is needed; equal priority stays asleep.
    assign prio_ok     = irq_pending && prio_above(irq_priority, cpu_priority); // (R4)
    assign irq_wake    = irq_can_wake(mode_q, prio_ok, irq_sleep_capable); // (R4) (R6)
    assign wdt_or_rst  = any_reset || watchdog_timeout; // (R5)
    assign bus_run     = clk_src_on(mode_q);
    assign start_entry = (mode_q != ST_START) && (mode_d == ST_START);

    // The bus clock runs in Run and Idle, not in Sleep or during start-up.
    pmbcs_pb_divider u_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .run     (bus_run), // (R7) (R14)
        .div_sel (periph_bus_divisor), // (R8) (R13) (R9)
        .pb_tick (pb_tick)
    );

    // Control register image; software writes steer mode and divisor.
    always @(posedge mclk) begin
        if (sys_rst) begin
            oscillator_control_reg <= `PMBCS_OSC_CTRL_RST;
        end else if (osc_ctrl_wr) begin
            oscillator_control_reg <= osc_ctrl_wdata;
        end
    end

    // Power mode sequencer. A wait is honoured only in Run; one that arrives in
    // any other mode is dropped, since a halted core cannot issue it.
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_RUN: begin
                if (wait_exec) begin
                    if (sleep_on_wait_select) begin
                        mode_d = ST_SLEEP; // (R14)
                    end else begin
                        mode_d = ST_IDLE; // (R1)
                    end
                end
            end
            ST_IDLE: begin
                // Exit from Idle goes straight to Run: the source never stopped.
                if (irq_wake || wdt_or_rst) begin
                    mode_d = ST_RUN; // (R4) (R5) (R11)
                end
            end
            ST_SLEEP: begin
                // Only a stopped crystal or PLL source pays the start-up time.
                if (irq_wake || wdt_or_rst) begin
                    mode_d = src_needs_start ? ST_START : ST_RUN; // (R6) (R11)
                end else if (irq_pending && irq_sleep_capable) begin
                    mode_d = ST_IDLE; // (R7)
                end
            end
            ST_START: begin
                if (dly_q == DLY_ZERO) begin
                    mode_d = ST_RUN; // (R11)
                end
            end
            default: begin
                mode_d = ST_RUN;
            end
        endcase
    end

    // Start-up counter, loaded one short so Start lasts START_DLY_CYC cycles.
    // A START_DLY_CYC of zero is not supported: it would wrap to the longest delay.
    always @* begin
        if (start_entry) begin
            dly_d = START_DLY_CYC - DLY_ONE; // (R11)
        end else if (dly_q != DLY_ZERO) begin
            dly_d = dly_q - DLY_ONE;
        end else begin
            dly_d = dly_q;
        end
    end

    // Mode and counter registers.
    always @(posedge mclk) begin
        if (sys_rst) begin
            mode_q <= ST_RUN;
            dly_q  <= DLY_ZERO;
        end else begin
            mode_q <= mode_d;
            dly_q  <= dly_d;
        end
    end

    // Core status outputs follow the next mode so they change with power_mode.
    always @(posedge mclk) begin
        if (sys_rst) begin
            cpu_halt             <= 1'b0;
            core_system_clock_en <= 1'b1;
            power_mode           <= ST_RUN;
            cpu_wake_irq         <= 1'b0;
        end else begin
            cpu_halt             <= (mode_d != ST_RUN); // (R2) (R7) (R14)
            core_system_clock_en <= clk_src_on(mode_d); // (R2) (R9)
            power_mode           <= mode_d;
            // Only a wake caused by the interrupt itself is flagged; a low-priority
            // Sleep wake into Idle or a source that is stopped in Sleep is not.
            cpu_wake_irq         <= irq_wake; // (R4) (R6)
        end
    end

    // Enables are one-cycle strobes aligned with each bus clock edge. Peripherals
    // that asked to stop in Idle lose their strobe from the second Idle cycle until the first cycle after Idle.
    always @(posedge mclk) begin
        if (sys_rst) begin
            peripheral_bus_clock_en <= 1'b0;
            periph_clk_en           <= PCLK_NONE;
        end else begin
            peripheral_bus_clock_en <= pb_tick; // (R9)
            if (mode_q == ST_IDLE) begin
                periph_clk_en <= {NUM_PERIPH{pb_tick}} & ~stop_in_idle_bit; // (R3)
            end else begin
                periph_clk_en <= {NUM_PERIPH{pb_tick}}; // (R9)
            end
        end
    end

    // A read waits for the next peripheral bus edge; at 1:8 this is 0 to 7 extra clocks.
    // One read at a time: a request made while another waits merges with it.
    always @(posedge mclk) begin
        if (sys_rst) begin
            rd_wait_q      <= 1'b0;
            periph_rd_done <= 1'b0;
        end else begin
            periph_rd_done <= 1'b0;
            if ((periph_rd_req || rd_wait_q) && pb_tick) begin
                rd_wait_q      <= 1'b0;
                periph_rd_done <= 1'b1; // (R10)
            end else if (periph_rd_req) begin
                rd_wait_q <= 1'b1;
            end
        end
    end

endmodule // pmbcs_power_ctrl
